// ==== logic/fwoc_regs.svh ====
// Register offsets, field positions, reset values and counts of the flash write control.
// Assumes a 32-bit AHB-Lite bus; each 16-bit register sits in the low half of one word.
`ifndef FWOC_REGS_SVH
`define FWOC_REGS_SVH
`define FWOC_OFF_CTRL0_LOW   6'h00
`define FWOC_OFF_CTRL0_HIGH  6'h04
`define FWOC_OFF_SECT_LOW    6'h08
`define FWOC_OFF_SECT_HIGH   6'h0c
`define FWOC_OFF_ADDR_LOW    6'h10
`define FWOC_OFF_ADDR_HIGH   6'h14
`define FWOC_OFF_DATA0_LOW   6'h18
`define FWOC_OFF_DATA0_HIGH  6'h1c
`define FWOC_OFF_DATA1_LOW   6'h20
`define FWOC_OFF_DATA1_HIGH  6'h24
`define FWOC_OFF_ERROR       6'h28
`define FWOC_OFF_TEMP_UNPROT 6'h2c
`define FWOC_OFF_STATUS      6'h30
`define FWOC_BIT_LAUNCH      15
`define FWOC_BIT_SUSPEND     14
`define FWOC_BIT_WORD        13
`define FWOC_BIT_DWORD       12
`define FWOC_BIT_ERASE       11
`define FWOC_BIT_PROTECT     8
`define FWOC_SEL_MASK        16'h3900
`define FWOC_BIT_RESUME_ERR  0
`define FWOC_NV_WPROT_ADDR   32'h0008dfb4
`define FWOC_NV_ACCP_ADDR    32'h0008dfb8
`define FWOC_NV_PERM_ADDR    32'h0008dfbc
`define FWOC_PERM_MAX        5'h10
`define FWOC_WPROT_RESET     16'hffff
`endif

// ==== logic/fwoc_pkg.sv ====
// Types of the flash write control: sequencer states and the request to the flash array.
// Assumes the constants of fwoc_regs.svh.
package fwoc_pkg;
  typedef enum logic [2:0] {
    FWOC_IDLE   = 3'h1,
    FWOC_RUN    = 3'h2,
    FWOC_HALTED = 3'h4
  } fwoc_state_t;

  // Operation handed to the flash array.
  typedef struct packed {
    logic [3:0]  op;
    logic [31:0] addr;
    logic [63:0] data;
    logic [31:0] sectors;
  } fwoc_req_t;
endpackage

// ==== logic/fwoc_top.sv ====
// Flash write operation control: AHB-Lite register slave and program/erase sequencer.
// Assumes a flash array that takes a request pulse and answers with a done pulse.
`timescale 1ns/1ps
`include "fwoc_regs.svh"
module fwoc_top (
  // Clock and reset.
  input  wire logic               REF_CLK_I,
  input  wire logic               RESETN_I,
  // AHB-Lite slave.
  input  wire logic               HSEL_I,
  input  wire logic [31:0]        HADDR_I,
  input  wire logic [1:0]         HTRANS_I,
  input  wire logic               HWRITE_I,
  input  wire logic [2:0]         HSIZE_I,
  input  wire logic [31:0]        HWDATA_I,
  input  wire logic               HREADY_I,
  output logic      [31:0]        HRDATA_O,
  output logic                    HREADYOUT_O,
  output logic                    HRESP_O,
  // Flash array side and processor status.
  input  wire logic               EXEC_FROM_FLASH_I,
  input  wire logic               FLASH_DONE_I,
  output fwoc_pkg::fwoc_req_t     FLASH_REQ_O,
  output logic                    FLASH_START_O,
  output logic                    FLASH_SUSPEND_O,
  output logic                    BUSY_O,
  output logic                    ACCESS_PROT_O,
  output logic      [15:0]        WRITE_PROT_O
);

  // Registers of the control block.
  logic [15:0]           ctrl0_low_q, ctrl0_low_d, ctrl0_high_q, ctrl0_high_d;
  logic [15:0]           sect_low_q, sect_low_d, sect_high_q, sect_high_d;
  logic [15:0]           addr_low_q, addr_low_d, addr_high_q, addr_high_d;
  logic [15:0]           d0_low_q, d0_low_d, d0_high_q, d0_high_d;
  logic [15:0]           d1_low_q, d1_low_d, d1_high_q, d1_high_d;
  logic                  res_err_q, res_err_d, tmp_unprot_q, tmp_unprot_d;
  logic                  accp_q, accp_d, perm_dis_q, perm_dis_d;
  logic [4:0]            perm_cnt_q, perm_cnt_d;
  logic [15:0]           wprot_q, wprot_d, orig_sel_q, orig_sel_d;
  fwoc_pkg::fwoc_state_t state_q, state_d;
  fwoc_pkg::fwoc_req_t   req_q, req_d;
  logic                  start_q, start_d, halt_q, halt_d;
  logic                  busy_q, busy_d, acc_prot_q, acc_prot_d;
  // Bus pipeline.
  logic                  wr_pend_q, wr_pend_d;
  logic [5:0]            wr_off_q, wr_off_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  protected_w, addr_ph;
  logic [15:0]           sel_w;
  logic [31:0]           tgt_addr;

  // True when exactly one operation select bit is set.
  function automatic logic one_sel(input logic [15:0] v);
    logic [15:0] m;
    m = v & `FWOC_SEL_MASK;
    return (m != 16'h0000) && ((m & (m - 16'h0001)) == 16'h0000);
  endfunction

  assign protected_w = !accp_q && !tmp_unprot_q && !perm_dis_q;
  assign addr_ph     = HSEL_I && HREADY_I && HTRANS_I[1];
  assign sel_w       = ctrl0_high_q & `FWOC_SEL_MASK;
  assign tgt_addr    = {addr_high_q, addr_low_q};

  // Bus capture and read data; reads are answered from a flop, so the slave never waits.
  always_comb
  begin
    wr_pend_d = addr_ph && HWRITE_I;
    wr_off_d  = HADDR_I[5:0];
    rdata_d   = rdata_q;
    if (addr_ph && !HWRITE_I)
    begin
      unique case (HADDR_I[5:0])
        `FWOC_OFF_CTRL0_LOW:   rdata_d = {16'h0000, ctrl0_low_q};
        `FWOC_OFF_CTRL0_HIGH:  rdata_d = {16'h0000, ctrl0_high_q};
        `FWOC_OFF_SECT_LOW:    rdata_d = {16'h0000, sect_low_q};
        `FWOC_OFF_SECT_HIGH:   rdata_d = {16'h0000, sect_high_q};
        `FWOC_OFF_ADDR_LOW:    rdata_d = {16'h0000, addr_low_q};
        `FWOC_OFF_ADDR_HIGH:   rdata_d = {16'h0000, addr_high_q};
        `FWOC_OFF_DATA0_LOW:   rdata_d = {16'h0000, d0_low_q};
        `FWOC_OFF_DATA0_HIGH:  rdata_d = {16'h0000, d0_high_q};
        `FWOC_OFF_DATA1_LOW:   rdata_d = {16'h0000, d1_low_q};
        `FWOC_OFF_DATA1_HIGH:  rdata_d = {16'h0000, d1_high_q};
        `FWOC_OFF_ERROR:       rdata_d = {31'h0, res_err_q};
        `FWOC_OFF_TEMP_UNPROT: rdata_d = {31'h0, tmp_unprot_q};
        `FWOC_OFF_STATUS:      rdata_d = {wprot_q, 8'h00, perm_cnt_q, perm_dis_q, accp_q, BUSY_O};
        default:               rdata_d = 32'h0;
      endcase
    end
  end

  // Register writes and the sequencer; hardware events override software in the same cycle.
  always_comb
  begin
    logic wr;
    logic [15:0] wd;
    wr = wr_pend_q;
    wd = HWDATA_I[15:0];
    ctrl0_low_d = ctrl0_low_q;   ctrl0_high_d = ctrl0_high_q;
    sect_low_d  = sect_low_q;    sect_high_d  = sect_high_q;
    addr_low_d  = addr_low_q;    addr_high_d  = addr_high_q;
    d0_low_d    = d0_low_q;      d0_high_d    = d0_high_q;
    d1_low_d    = d1_low_q;      d1_high_d    = d1_high_q;
    res_err_d   = res_err_q;     tmp_unprot_d = tmp_unprot_q;
    accp_d      = accp_q;        perm_dis_d   = perm_dis_q;
    perm_cnt_d  = perm_cnt_q;    wprot_d      = wprot_q;
    orig_sel_d  = orig_sel_q;    state_d      = state_q;
    req_d       = req_q;
    start_d     = 1'b0;
    halt_d      = 1'b0;
    // Temporary unprotect is always writable, but a one only sticks from flash execution.
    if (wr && wr_off_q == `FWOC_OFF_TEMP_UNPROT)
      tmp_unprot_d = wd[0] && EXEC_FROM_FLASH_I;
    // Protected flash refuses every control write except to temporary unprotect; the error flag clears on a write of one.
    if (wr && !protected_w)
    begin
      unique case (wr_off_q)
        `FWOC_OFF_CTRL0_LOW:  ctrl0_low_d  = wd;
        `FWOC_OFF_CTRL0_HIGH: ctrl0_high_d = wd;
        `FWOC_OFF_SECT_LOW:   sect_low_d   = wd;
        `FWOC_OFF_SECT_HIGH:  sect_high_d  = wd;
        `FWOC_OFF_ADDR_LOW:   addr_low_d   = wd;
        `FWOC_OFF_ADDR_HIGH:  addr_high_d  = wd;
        `FWOC_OFF_DATA0_LOW:  d0_low_d     = wd;
        `FWOC_OFF_DATA0_HIGH: d0_high_d    = wd;
        `FWOC_OFF_DATA1_LOW:  d1_low_d     = wd;
        `FWOC_OFF_DATA1_HIGH: d1_high_d    = wd;
        `FWOC_OFF_ERROR:      res_err_d    = res_err_q && !wd[`FWOC_BIT_RESUME_ERR];
        default:              ;
      endcase
    end
    unique case (state_q)
      fwoc_pkg::FWOC_IDLE:
      begin
        if (ctrl0_high_q[`FWOC_BIT_LAUNCH])
        begin
          ctrl0_high_d[`FWOC_BIT_LAUNCH] = 1'b0;
          if (one_sel(ctrl0_high_q) && ctrl0_high_q[`FWOC_BIT_PROTECT])
          begin
            if (tgt_addr == `FWOC_NV_WPROT_ADDR)
              wprot_d = d0_low_q;
            else if (tgt_addr == `FWOC_NV_ACCP_ADDR)
              accp_d = d0_low_q[1:0] != 2'b00;
            else if (tgt_addr == `FWOC_NV_PERM_ADDR && tmp_unprot_q)
            begin
              // Each disable spends one of the limited permanent cycles.
              if (!d0_low_q[0] && !perm_dis_q && perm_cnt_q < `FWOC_PERM_MAX)
              begin
                perm_dis_d = 1'b1;
                perm_cnt_d = perm_cnt_q + 5'h01;
              end
              else if (!d0_high_q[0] && perm_dis_q)
                perm_dis_d = 1'b0;
            end
          end
          else if (one_sel(ctrl0_high_q))
          begin
            state_d     = fwoc_pkg::FWOC_RUN;
            start_d     = 1'b1;
            orig_sel_d  = sel_w;
            req_d.op    = {sel_w[`FWOC_BIT_WORD], sel_w[`FWOC_BIT_DWORD], sel_w[`FWOC_BIT_ERASE], 1'b0};
            req_d.addr  = sel_w[`FWOC_BIT_DWORD] ? {tgt_addr[31:3], 3'b000} : tgt_addr;
            req_d.data  = {d1_high_q, d1_low_q, d0_high_q, d0_low_q};
            req_d.sectors = {sect_high_q, sect_low_q};
          end
        end
      end
      fwoc_pkg::FWOC_RUN:
      begin
        if (FLASH_DONE_I)
        begin
          state_d = fwoc_pkg::FWOC_IDLE;
          ctrl0_high_d[`FWOC_BIT_LAUNCH] = 1'b0;
          if (orig_sel_q[`FWOC_BIT_ERASE])
          begin
            sect_low_d  = 16'h0000;
            sect_high_d = 16'h0000;
          end
        end
        else if (ctrl0_high_q[`FWOC_BIT_SUSPEND])
        begin
          state_d = fwoc_pkg::FWOC_HALTED;
          halt_d  = 1'b1;
          ctrl0_high_d[`FWOC_BIT_LAUNCH]  = 1'b0;
          ctrl0_high_d[`FWOC_BIT_SUSPEND] = 1'b0;
        end
      end
      fwoc_pkg::FWOC_HALTED:
      begin
        if (ctrl0_high_q[`FWOC_BIT_LAUNCH])
        begin
          ctrl0_high_d[`FWOC_BIT_LAUNCH] = 1'b0;
          if (sel_w == orig_sel_q)
          begin
            state_d = fwoc_pkg::FWOC_RUN;
            start_d = 1'b1;
          end
          else
          begin
            state_d   = fwoc_pkg::FWOC_IDLE;
            res_err_d = 1'b1;
          end
        end
      end
    endcase
    // Busy and protection are registered so that these outputs come straight from flops.
    busy_d     = state_d == fwoc_pkg::FWOC_RUN;
    acc_prot_d = !accp_d && !tmp_unprot_d && !perm_dis_d;
  end

  // State registers; non-volatile protection is modelled as erased (unprotected) at reset.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ctrl0_low_q <= 16'h0000; ctrl0_high_q <= 16'h0000;
      sect_low_q  <= 16'h0000; sect_high_q  <= 16'h0000;
      addr_low_q  <= 16'h0000; addr_high_q  <= 16'h0000;
      d0_low_q    <= 16'h0000; d0_high_q    <= 16'h0000;
      d1_low_q    <= 16'h0000; d1_high_q    <= 16'h0000;
      res_err_q   <= 1'b0;     tmp_unprot_q <= 1'b0;
      accp_q      <= 1'b1;     perm_dis_q   <= 1'b0;
      perm_cnt_q  <= 5'h00;    wprot_q      <= `FWOC_WPROT_RESET;
      orig_sel_q  <= 16'h0000; state_q      <= fwoc_pkg::FWOC_IDLE;
      req_q       <= '0;       start_q      <= 1'b0;
      halt_q      <= 1'b0;     wr_pend_q    <= 1'b0;
      wr_off_q    <= 6'h00;    rdata_q      <= 32'h0;
      busy_q      <= 1'b0;     acc_prot_q   <= 1'b0;
    end
    else
    begin
      ctrl0_low_q <= ctrl0_low_d; ctrl0_high_q <= ctrl0_high_d;
      sect_low_q  <= sect_low_d;  sect_high_q  <= sect_high_d;
      addr_low_q  <= addr_low_d;  addr_high_q  <= addr_high_d;
      d0_low_q    <= d0_low_d;    d0_high_q    <= d0_high_d;
      d1_low_q    <= d1_low_d;    d1_high_q    <= d1_high_d;
      res_err_q   <= res_err_d;   tmp_unprot_q <= tmp_unprot_d;
      accp_q      <= accp_d;      perm_dis_q   <= perm_dis_d;
      perm_cnt_q  <= perm_cnt_d;  wprot_q      <= wprot_d;
      orig_sel_q  <= orig_sel_d;  state_q      <= state_d;
      req_q       <= req_d;       start_q      <= start_d;
      halt_q      <= halt_d;      wr_pend_q    <= wr_pend_d;
      wr_off_q    <= wr_off_d;    rdata_q      <= rdata_d;
      busy_q      <= busy_d;      acc_prot_q   <= acc_prot_d;
    end
  end

  // Outputs straight from flops; the slave is zero-wait and always answers OKAY.
  assign HRDATA_O        = rdata_q;
  assign HREADYOUT_O     = 1'b1;
  assign HRESP_O         = 1'b0;
  assign FLASH_REQ_O     = req_q;
  assign FLASH_START_O   = start_q;
  assign FLASH_SUSPEND_O = halt_q;
  assign BUSY_O          = busy_q;
  assign ACCESS_PROT_O   = acc_prot_q;
  assign WRITE_PROT_O    = wprot_q;

  // Checks.
  sequence s_launch_bad;
    state_q == fwoc_pkg::FWOC_IDLE && ctrl0_high_q[`FWOC_BIT_LAUNCH] && !one_sel(ctrl0_high_q);
  endsequence
  property p_no_bad_start;
    @(posedge REF_CLK_I) disable iff (!RESETN_I) s_launch_bad |=> !start_q && !BUSY_O;
  endproperty
  a_no_bad_start: assert property (p_no_bad_start) else $error("Bad select launched.");
  property p_start_busy;
    @(posedge REF_CLK_I) disable iff (!RESETN_I) start_q |-> BUSY_O;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("Start without busy.");
  property p_launch_clr;
    @(posedge REF_CLK_I) disable iff (!RESETN_I) BUSY_O && FLASH_DONE_I |=> !BUSY_O && !ctrl0_high_q[15];
  endproperty
  a_launch_clr: assert property (p_launch_clr) else $error("Launch not cleared.");
  property p_erase_clr;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      BUSY_O && FLASH_DONE_I && orig_sel_q[11] |=> sect_low_q == 16'h0000 && sect_high_q == 16'h0000;
  endproperty
  a_erase_clr: assert property (p_erase_clr) else $error("Sectors not cleared.");
  property p_suspend;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      BUSY_O && !FLASH_DONE_I && ctrl0_high_q[14] |=> FLASH_SUSPEND_O && !BUSY_O ##1 !FLASH_SUSPEND_O;
  endproperty
  a_suspend: assert property (p_suspend) else $error("Suspend not taken.");
  property p_abort;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      state_q == fwoc_pkg::FWOC_HALTED && ctrl0_high_q[15] && sel_w != orig_sel_q |=> res_err_q && !start_q;
  endproperty
  a_abort: assert property (p_abort) else $error("Resume mismatch not aborted.");
  property p_dword_align;
    @(posedge REF_CLK_I) disable iff (!RESETN_I) start_q && FLASH_REQ_O.op[2] |-> FLASH_REQ_O.addr[2:0] == 3'b000;
  endproperty
  a_dword_align: assert property (p_dword_align) else $error("Double word misaligned.");
  property p_perm_max;
    @(posedge REF_CLK_I) disable iff (!RESETN_I) perm_cnt_q <= `FWOC_PERM_MAX;
  endproperty
  a_perm_max: assert property (p_perm_max) else $error("Permanent cycle limit broken.");
  property p_perm_unprot;
    @(posedge REF_CLK_I) disable iff (!RESETN_I) perm_dis_q && !$past(perm_dis_q) |-> $past(tmp_unprot_q);
  endproperty
  a_perm_unprot: assert property (p_perm_unprot) else $error("Permanent disable without unprotect.");
  property p_protect_block;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_pend_q && protected_w && wr_off_q == `FWOC_OFF_ADDR_LOW |=> $stable(addr_low_q);
  endproperty
  a_protect_block: assert property (p_protect_block) else $error("Protected write accepted.");
endmodule

// ==== tb/fwoc_top_tb.sv ====
// Self-checking testbench of the flash write operation control, driven over AHB-Lite.
// Assumes fwoc_pkg is compiled first and fwoc_regs.svh is on the include path.
`timescale 1ns/1ps
`include "fwoc_regs.svh"
module fwoc_top_tb;
  logic                ref_clk;
  logic                resetn;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hready;
  logic                hresp;
  logic                exec_flash;
  logic                flash_done;
  fwoc_pkg::fwoc_req_t req;
  logic                start;
  logic                halted;
  logic                busy;
  logic                acc_prot;
  logic [15:0]         wprot;
  logic [31:0]         rd;
  int                  n_mismatch;
  int                  comparisons;

  // The single slave's ready is the bus ready, so it is looped back.
  fwoc_top fwoc_top_inst (
    .REF_CLK_I         (ref_clk),
    .RESETN_I          (resetn),
    .HSEL_I            (1'b1),
    .HADDR_I           (haddr),
    .HTRANS_I          (htrans),
    .HWRITE_I          (hwrite),
    .HSIZE_I           (3'h2),
    .HWDATA_I          (hwdata),
    .HREADY_I          (hready),
    .HRDATA_O          (hrdata),
    .HREADYOUT_O       (hready),
    .HRESP_O           (hresp),
    .EXEC_FROM_FLASH_I (exec_flash),
    .FLASH_DONE_I      (flash_done),
    .FLASH_REQ_O       (req),
    .FLASH_START_O     (start),
    .FLASH_SUSPEND_O   (halted),
    .BUSY_O            (busy),
    .ACCESS_PROT_O     (acc_prot),
    .WRITE_PROT_O      (wprot)
  );

  // A 100 ns clock.
  always #50 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One single transfer; the leading edge leaves an idle cycle after the previous data phase.
  task automatic bus(input logic wr, input logic [5:0] off, input logic [15:0] d);
    @(posedge ref_clk);
    haddr  <= {26'h0, off};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Select, load address, data and sectors, then launch.
  task automatic prog(input logic [15:0] sel, input logic [31:0] a, input logic [31:0] d0,
                      input logic [31:0] d1, input logic [31:0] s);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, sel);
    bus(1'b1, `FWOC_OFF_ADDR_LOW, a[15:0]);
    bus(1'b1, `FWOC_OFF_ADDR_HIGH, a[31:16]);
    bus(1'b1, `FWOC_OFF_DATA0_LOW, d0[15:0]);
    bus(1'b1, `FWOC_OFF_DATA0_HIGH, d0[31:16]);
    bus(1'b1, `FWOC_OFF_DATA1_LOW, d1[15:0]);
    bus(1'b1, `FWOC_OFF_DATA1_HIGH, d1[31:16]);
    bus(1'b1, `FWOC_OFF_SECT_LOW, s[15:0]);
    bus(1'b1, `FWOC_OFF_SECT_HIGH, s[31:16]);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, sel | 16'h8000);
  endtask

  // Start and suspend are one-cycle pulses, so every cycle of the window is looked at.
  task automatic expect_pulse(input bit which, input logic exp, input string what);
    logic seen;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      #1;
      if ((which ? halted : start) === 1'b1)
        seen = 1'b1;
    end
    check(what, seen, exp);
  endtask

  task automatic finish_op();
    @(posedge ref_clk);
    flash_done <= 1'b1;
    @(posedge ref_clk);
    flash_done <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("busy after done", busy, 1'b0);
  endtask

  task automatic t_reset();
    bus(1'b1, 6'h3c, 16'hffff);
    bus(1'b0, 6'h3c, 16'h0);
    check("unmapped read", rd, 32'h0);
    bus(1'b0, `FWOC_OFF_STATUS, 16'h0);
    check("status", rd, 32'hffff0002);
    check("write protect", wprot, 16'hffff);
    check("response", hresp, 1'b0);
    $display("done: reset");
  endtask

  task automatic t_word();
    prog(16'h2000, 32'h00025554, 32'haaaaaaaa, 32'h0, 32'h0);
    expect_pulse(1'b0, 1'b1, "word start");
    check("busy", busy, 1'b1);
    check("word op", req.op, 4'h8);
    check("word addr", req.addr, 32'h00025554);
    check("word data", req.data[31:0], 32'haaaaaaaa);
    finish_op();
    bus(1'b0, `FWOC_OFF_CTRL0_HIGH, 16'h0);
    check("launch cleared", rd[15], 1'b0);
    $display("done: word program");
  endtask

  task automatic t_dword();
    prog(16'h1000, 32'h0003555c, 32'h55aa55aa, 32'haa55aa55, 32'h0);
    expect_pulse(1'b0, 1'b1, "dword start");
    check("dword op", req.op, 4'h4);
    check("dword addr", req.addr, 32'h00035558);
    check("dword data", req.data, 64'haa55aa5555aa55aa);
    finish_op();
    $display("done: double word program");
  endtask

  task automatic t_erase();
    prog(16'h0800, 32'h0, 32'h0, 32'h0, 32'h00010003);
    expect_pulse(1'b0, 1'b1, "erase start");
    check("erase op", req.op, 4'h2);
    check("erase sectors", req.sectors, 32'h00010003);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h4800);
    expect_pulse(1'b1, 1'b1, "suspend");
    check("busy suspended", busy, 1'b0);
    bus(1'b0, `FWOC_OFF_SECT_LOW, 16'h0);
    check("sectors kept", rd, 32'h3);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h0800);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h8800);
    expect_pulse(1'b0, 1'b1, "resume start");
    finish_op();
    bus(1'b0, `FWOC_OFF_SECT_LOW, 16'h0);
    check("sectors low cleared", rd, 32'h0);
    bus(1'b0, `FWOC_OFF_SECT_HIGH, 16'h0);
    check("sectors high cleared", rd, 32'h0);
    $display("done: erase, suspend, resume");
  endtask

  task automatic t_abort();
    prog(16'h2000, 32'h00001000, 32'h12345678, 32'h0, 32'h0);
    expect_pulse(1'b0, 1'b1, "word start");
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h6000);
    expect_pulse(1'b1, 1'b1, "suspend word");
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h1000);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h9000);
    expect_pulse(1'b0, 1'b0, "mismatched resume");
    check("busy after abort", busy, 1'b0);
    bus(1'b0, `FWOC_OFF_ERROR, 16'h0);
    check("resume error", rd[0], 1'b1);
    bus(1'b1, `FWOC_OFF_ERROR, 16'h0001);
    bus(1'b0, `FWOC_OFF_ERROR, 16'h0);
    check("resume error cleared", rd[0], 1'b0);
    $display("done: resume abort");
  endtask

  task automatic t_select();
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h2000);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h0000);
    bus(1'b1, `FWOC_OFF_CTRL0_HIGH, 16'h8000);
    expect_pulse(1'b0, 1'b0, "cancelled start");
    prog(16'h3000, 32'h0, 32'h0, 32'h0, 32'h0);
    expect_pulse(1'b0, 1'b0, "double select");
    bus(1'b0, `FWOC_OFF_CTRL0_HIGH, 16'h0);
    check("refused launch", rd[15], 1'b0);
    $display("done: cancel and refused selects");
  endtask

  task automatic t_protect();
    prog(16'h0100, `FWOC_NV_WPROT_ADDR, 32'hfffffff0, 32'h0, 32'h0);
    expect_pulse(1'b0, 1'b0, "protect start");
    check("write protect", wprot, 16'hfff0);
    prog(16'h0100, `FWOC_NV_ACCP_ADDR, 32'hfffffffc, 32'h0, 32'h0);
    expect_pulse(1'b0, 1'b0, "access start");
    check("access protect", acc_prot, 1'b1);
    bus(1'b1, `FWOC_OFF_ADDR_LOW, 16'h1234);
    bus(1'b0, `FWOC_OFF_ADDR_LOW, 16'h0);
    check("blocked write", rd, 32'hdfb8);
    bus(1'b1, `FWOC_OFF_TEMP_UNPROT, 16'h0001);
    bus(1'b0, `FWOC_OFF_TEMP_UNPROT, 16'h0);
    check("unprotect outside flash", rd, 32'h0);
    exec_flash <= 1'b1;
    bus(1'b1, `FWOC_OFF_TEMP_UNPROT, 16'h0001);
    bus(1'b0, `FWOC_OFF_TEMP_UNPROT, 16'h0);
    check("unprotect from flash", rd, 32'h1);
    check("protection lifted", acc_prot, 1'b0);
    // The seventeenth disable must be refused and the count must stay at its ceiling.
    for (int i = 0; i < 17; i++)
    begin
      prog(16'h0100, `FWOC_NV_PERM_ADDR, 32'hfffffffe, 32'h0, 32'h0);
      bus(1'b0, `FWOC_OFF_STATUS, 16'h0);
      check("disable count", rd[7:2], (i < 16) ? {5'(i + 1), 1'b1} : {`FWOC_PERM_MAX, 1'b0});
      prog(16'h0100, `FWOC_NV_PERM_ADDR, 32'hfffeffff, 32'h0, 32'h0);
      bus(1'b0, `FWOC_OFF_STATUS, 16'h0);
      check("re-enabled", rd[2], 1'b0);
    end
    bus(1'b1, `FWOC_OFF_TEMP_UNPROT, 16'h0000);
    bus(1'b0, `FWOC_OFF_STATUS, 16'h0);
    check("protection restored", acc_prot, 1'b1);
    $display("done: protection");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence; protection comes last because it leaves the registers locked.
  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    exec_flash = 1'b0;
    flash_done = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_word();
    t_dword();
    t_erase();
    t_abort();
    t_select();
    t_protect();
    report_and_stop();
  end

  // The run needs some fifteen hundred cycles; a hang is cut off well beyond that.
  initial
  begin
    repeat (8000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
